// file: core/bc_bcf_pkg.sv
package bc_bcf_pkg;

	// instruction word geometry
	localparam int INSTR_W          = 16;
	localparam int PC_W             = 21;
	localparam int DADDR_W          = 12;
	localparam int BANK_W           = 4;

	// carry branch encoding: upper byte of the word
	localparam logic [7:0] BRANCH_CARRY_OPC  = 8'hE2;
	localparam int         BRANCH_OPC_LSB    = 8;
	// bit clear encoding: leading nibble
	localparam logic [3:0] BIT_CLEAR_OPC     = 4'h9;
	localparam int         BIT_CLEAR_OPC_LSB = 12;
	localparam int         BIT_IDX_LSB       = 9;
	localparam int         ACC_SEL_POS       = 8;

	// fixed part of the branch target, in bytes
	localparam logic [PC_W-1:0] BRANCH_BASE_STEP = 21'h000002;

	// access bank split: low part maps to bank 0, high part to the top bank
	localparam logic [7:0]        ACCESS_SPLIT    = 8'h60;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_TOP_BANK = 4'hF;

	// reset values
	localparam logic [PC_W-1:0]    PC_RST    = 21'h000000;
	localparam logic [DADDR_W-1:0] DADDR_RST = 12'h000;
	localparam logic [7:0]         BYTE_RST  = 8'h00;

	typedef enum logic [0:0]
	{
		ST_EXEC  = 1'b0,
		ST_FLUSH = 1'b1
	} exec_state_t;

	typedef struct packed
	{
		logic [2:0] bit_idx;
		logic       acc_sel;
		logic [7:0] file_addr;
	} bit_clear_fields_t;

	typedef struct packed
	{
		logic              wr_en;
		logic [DADDR_W-1:0] addr;
		logic [7:0]        data;
	} mem_write_t;

endpackage

// file: core/file_addr_resolve.sv
`timescale 1ns/100ps

// data memory address of a bit clear operand
module file_addr_resolve
	import bc_bcf_pkg::*;
(
	input  wire logic [7:0]         file_addr_in,
	input  wire logic               acc_sel_in,
	input  wire logic [BANK_W-1:0]  bank_select_reg_in,
	input  wire logic               ext_set_en_in,
	input  wire logic [DADDR_W-1:0] index_base_in,
	output      logic [DADDR_W-1:0] daddr_out,
	output      logic               indexed_out
);

	wire logic                low_half;
	wire logic [DADDR_W-1:0]  banked_addr;
	wire logic [DADDR_W-1:0]  access_addr;
	wire logic [DADDR_W-1:0]  indexed_addr;

	// access bank halves and the two alternative forms
	assign low_half     = file_addr_in < ACCESS_SPLIT;
	assign banked_addr  = {bank_select_reg_in, file_addr_in};
	assign access_addr  = {low_half ? ACCESS_LOW_BANK : ACCESS_TOP_BANK,
		file_addr_in};
	// offset wraps within data space, as the pointer itself would
	assign indexed_addr = index_base_in + {4'h0, file_addr_in};

	// only low-half addresses qualify for the indexed form
	assign indexed_out = !acc_sel_in && ext_set_en_in && low_half;
	assign daddr_out   = acc_sel_in  ? banked_addr :
		(indexed_out ? indexed_addr : access_addr);

endmodule

// file: core/carry_branch_and_bit_clear_exec.sv
`timescale 1ns/100ps

// Function
// - Word E2nn is the carry branch with signed offset nn, taken only when carry is one.
// - A taken branch loads the program counter with instruction address plus two plus 2n.
// - The branch takes one cycle untaken and two when taken, the second being a no-op.
// - Word 9bbbaffffffff clears bit b of the addressed file register.
// - With the access selector low and the extended set off the address falls in the access bank.
// - With the access selector high the bank select register forms the upper address.
// - Access selector low with the extended set on uses indexed literal offset addressing for file addresses below 60h.
module carry_branch_and_bit_clear_exec
	import bc_bcf_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               instr_valid_in,
	input  wire logic [INSTR_W-1:0] instr_in,
	input  wire logic [PC_W-1:0]    program_counter_in,
	input  wire logic               carry_flag_in,
	input  wire logic [BANK_W-1:0]  bank_select_reg_in,
	input  wire logic               ext_set_en_in,
	input  wire logic [DADDR_W-1:0] index_base_in,
	input  wire logic [7:0]         mem_rd_data_in,
	output      logic [DADDR_W-1:0] mem_rd_addr_out,
	output      logic               mem_rd_en_out,
	output      logic               mem_wr_en_out,
	output      logic [DADDR_W-1:0] mem_wr_addr_out,
	output      logic [7:0]         mem_wr_data_out,
	output      logic               pc_load_out,
	output      logic [PC_W-1:0]    pc_target_out,
	output      logic               nop_cycle_out,
	output      logic               instr_ready_out
);

	exec_state_t        state_q;
	exec_state_t        state_d;
	mem_write_t         wr_q;
	mem_write_t         wr_d;
	logic               pc_load_q;
	logic [PC_W-1:0]    pc_target_q;
	logic [PC_W-1:0]    pc_target_d;

	wire logic              accept;
	wire logic              is_branch;
	wire logic              is_bit_clear;
	wire logic              branch_taken;
	wire logic [PC_W-1:0]   branch_target;
	wire bit_clear_fields_t bcf;
	wire logic [DADDR_W-1:0] clr_addr;
	wire logic [7:0]        rd_fwd;
	wire logic [7:0]        clr_mask;
	wire logic [7:0]        clr_result;

	// twice the sign-extended offset, in program counter width
	function automatic logic [PC_W-1:0] offset_x2(input logic [7:0] n);
		offset_x2 = {{(PC_W-9){n[7]}}, n, 1'b0};
	endfunction

	// one-cold mask with the selected bit low
	function automatic logic [7:0] clear_mask(input logic [2:0] idx);
		clear_mask = ~(8'h01 << idx);
	endfunction

	// the slot after a taken branch is refused
	assign instr_ready_out = state_q == ST_EXEC;
	assign accept          = instr_valid_in && instr_ready_out;

	// decode
	assign is_branch    = accept &&
		instr_in[INSTR_W-1:BRANCH_OPC_LSB] == BRANCH_CARRY_OPC;
	assign is_bit_clear = accept &&
		instr_in[INSTR_W-1:BIT_CLEAR_OPC_LSB] == BIT_CLEAR_OPC;
	assign branch_taken = is_branch && carry_flag_in;

	// target counts from the branch's own address
	assign branch_target = program_counter_in + BRANCH_BASE_STEP
		+ offset_x2(instr_in[7:0]);

	// bit clear operand fields
	assign bcf.bit_idx   = instr_in[BIT_IDX_LSB +: 3];
	assign bcf.acc_sel   = instr_in[ACC_SEL_POS];
	assign bcf.file_addr = instr_in[7:0];

	file_addr_resolve u_addr
	(
		.file_addr_in      (bcf.file_addr),
		.acc_sel_in        (bcf.acc_sel),
		.bank_select_reg_in(bank_select_reg_in),
		.ext_set_en_in     (ext_set_en_in),
		.index_base_in     (index_base_in),
		.daddr_out         (clr_addr),
		.indexed_out       ()
	);

	// read this cycle, write back next; a write still pending to the same
	// byte is forwarded so back-to-back clears do not lose each other
	assign mem_rd_en_out   = is_bit_clear;
	assign mem_rd_addr_out = clr_addr;
	assign rd_fwd          = (wr_q.wr_en && wr_q.addr == clr_addr) ?
		wr_q.data : mem_rd_data_in;
	assign clr_mask        = clear_mask(bcf.bit_idx);
	assign clr_result      = rd_fwd & clr_mask;

	// write-back and branch outcome; no flag output exists at all
	// one driver for the whole write record keeps it a single continuous assignment
	assign wr_d = '{wr_en: is_bit_clear, addr: clr_addr, data: clr_result};
	assign pc_target_d = branch_taken ? branch_target : pc_target_q;

	// taken branch spends one extra slot as a no-op while refetching
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_EXEC:
			begin
				if (branch_taken)
				begin
					state_d = ST_FLUSH;
				end
			end
			ST_FLUSH:
			begin
				state_d = ST_EXEC;
			end
			default:
			begin
				state_d = ST_EXEC;
			end
		endcase
	end

	// state and registered outputs
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q     <= ST_EXEC;
			wr_q        <= '{wr_en: 1'b0, addr: DADDR_RST, data: BYTE_RST};
			pc_load_q   <= 1'b0;
			pc_target_q <= PC_RST;
		end
		else
		begin
			state_q     <= state_d;
			wr_q        <= wr_d;
			pc_load_q   <= branch_taken;
			pc_target_q <= pc_target_d;
		end
	end

	assign mem_wr_en_out   = wr_q.wr_en;
	assign mem_wr_addr_out = wr_q.addr;
	assign mem_wr_data_out = wr_q.data;
	assign pc_load_out     = pc_load_q;
	assign pc_target_out   = pc_target_q;
	assign nop_cycle_out   = state_q == ST_FLUSH;

endmodule

// file: tb/carry_branch_and_bit_clear_exec_checker.sv
`timescale 1ns/100ps
module carry_branch_and_bit_clear_exec_checker
	import bc_bcf_pkg::*;
(
	input wire logic               clk_in,
	input wire logic               rst_n_in,
	input wire logic               instr_valid_in,
	input wire logic [INSTR_W-1:0] instr_in,
	input wire logic [PC_W-1:0]    program_counter_in,
	input wire logic               carry_flag_in,
	input wire logic               mem_rd_en_out,
	input wire logic               mem_wr_en_out,
	input wire logic               pc_load_out,
	input wire logic [PC_W-1:0]    pc_target_out,
	input wire logic               nop_cycle_out,
	input wire logic               instr_ready_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// accepted words of each kind and the branch target they imply
	wire            go = instr_valid_in && instr_ready_out;
	wire            br = go && instr_in[15:8] == BRANCH_CARRY_OPC;
	wire            cl = go && instr_in[15:12] == BIT_CLEAR_OPC;
	wire [PC_W-1:0] tg = program_counter_in + BRANCH_BASE_STEP + {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
	a_branch_target: assert property (br && carry_flag_in |=> pc_load_out && pc_target_out == $past(tg))
		else $error("branch target wrong");
	a_untaken_quiet: assert property (br && !carry_flag_in |=> !pc_load_out)
		else $error("untaken branch loaded");
	a_load_cause: assert property (pc_load_out |-> $past(br) && $past(carry_flag_in))
		else $error("load without taken branch");
	a_nop_slot: assert property (pc_load_out |-> nop_cycle_out && !instr_ready_out)
		else $error("no nop slot");
	a_nop_once: assert property (nop_cycle_out |=> !nop_cycle_out)
		else $error("nop slot too long");
	a_ready_idle: assert property (!nop_cycle_out |-> instr_ready_out)
		else $error("ready low outside nop");
	a_refused_word: assert property (nop_cycle_out |=> !pc_load_out && !mem_wr_en_out)
		else $error("word taken in nop slot");
	a_clear_rmw: assert property (cl |-> mem_rd_en_out ##1 mem_wr_en_out)
		else $error("clear not read then written");
	a_write_cause: assert property (mem_wr_en_out |-> $past(mem_rd_en_out))
		else $error("write without read");
endmodule

// file: tb/data_mem_model.sv
`timescale 1ns/100ps
module data_mem_model
	import bc_bcf_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               rd_en_in,
	input  wire logic [DADDR_W-1:0] rd_addr_in,
	output      logic [7:0]         rd_data_out,
	input  wire logic               wr_en_in,
	input  wire logic [DADDR_W-1:0] wr_addr_in,
	input  wire logic [7:0]         wr_data_in
);
	logic [7:0] mem [4096];
	// fill pattern matches the bench shadow copy
	initial
		for (int i = 0; i < 4096; i++)
			mem[i] = i[7:0] ^ 8'h5A;
	// inverted when unselected so a stale sample shows
	assign rd_data_out = rd_en_in ? mem[rd_addr_in] : ~mem[rd_addr_in];
	always @(posedge clk_in)
		if (wr_en_in)
			mem[wr_addr_in] <= wr_data_in;
endmodule

// file: tb/tb_carry_branch_and_bit_clear_exec.sv
`timescale 1ns/100ps
module tb_carry_branch_and_bit_clear_exec;
	import bc_bcf_pkg::*;
	logic clk_in, rst_n_in, instr_valid_in, carry_flag_in, ext_set_en_in, e_ld, e_wr, acc, cl, br;
	logic mem_rd_en_out, mem_wr_en_out, pc_load_out, nop_cycle_out, instr_ready_out;
	logic [DADDR_W-1:0] mem_rd_addr_out, mem_wr_addr_out, index_base_in, e_wa, a;
	logic [7:0] mem_rd_data_in, mem_wr_data_out, e_wd, f, off, sh [4096];
	logic [PC_W-1:0] program_counter_in, pc_target_out, e_tg;
	logic [INSTR_W-1:0] instr_in;
	logic [BANK_W-1:0] bank_select_reg_in;
	logic [31:0] r, w;
	int seed = 32, n_fail = 0, check_count = 0;
	carry_branch_and_bit_clear_exec u_carry_branch_and_bit_clear_exec (.clk_in, .rst_n_in,
		.instr_valid_in, .instr_in, .program_counter_in, .carry_flag_in, .bank_select_reg_in,
		.ext_set_en_in, .index_base_in, .mem_rd_data_in, .mem_rd_addr_out, .mem_rd_en_out,
		.mem_wr_en_out, .mem_wr_addr_out, .mem_wr_data_out, .pc_load_out, .pc_target_out,
		.nop_cycle_out, .instr_ready_out);
	data_mem_model u_data_mem_model (.clk_in, .rd_en_in(mem_rd_en_out), .rd_addr_in(mem_rd_addr_out),
		.rd_data_out(mem_rd_data_in), .wr_en_in(mem_wr_en_out), .wr_addr_in(mem_wr_addr_out),
		.wr_data_in(mem_wr_data_out));
	always #12.5 clk_in = ~clk_in;
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (e !== g)
		begin
			n_fail++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// random word mix; first words force extreme offsets and two refused slots
	initial
	begin
		{clk_in, rst_n_in, instr_valid_in, carry_flag_in, ext_set_en_in, e_ld, e_wr} = '0;
		{instr_in, program_counter_in, bank_select_reg_in, index_base_in} = '0;
		for (int i = 0; i < 4096; i++)
			sh[i] = i[7:0] ^ 8'h5A;
		repeat (6) @(posedge clk_in);
		cmp("reset", 5'h01, {mem_wr_en_out, pc_load_out, nop_cycle_out, mem_rd_en_out, instr_ready_out});
		#2 rst_n_in = 1;
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk_in);
			#2;
			cmp("pc_load", e_ld, pc_load_out);
			if (e_ld) cmp("pc_target", e_tg, pc_target_out);
			cmp("nop", e_ld, nop_cycle_out);
			cmp("wr_en", e_wr, mem_wr_en_out);
			if (e_wr) cmp("wr_word", {e_wa, e_wd}, {mem_wr_addr_out, mem_wr_data_out});
			r = $random(seed);
			w = $random(seed);
			off = i[1] ? 8'h80 : 8'h7F;
			if (i >= 4) off = w[29:22];
			instr_valid_in = r[2:0] != 0 || i < 4;
			carry_flag_in = r[3] || i < 4;
			ext_set_en_in = r[4];
			bank_select_reg_in = r[8:5];
			index_base_in = r[20:9];
			program_counter_in = {w[20:1], 1'b0};
			case (i < 4 ? 2'd0 : w[31:30])
				2'd0: instr_in = {BRANCH_CARRY_OPC, off};
				2'd3: instr_in = {4'h0, w[11:0]};
				default: instr_in = {BIT_CLEAR_OPC, w[11:0]};
			endcase
			#1;
			acc = instr_valid_in && !e_ld;
			cl = acc && instr_in[15:12] == BIT_CLEAR_OPC;
			br = acc && instr_in[15:8] == BRANCH_CARRY_OPC && carry_flag_in;
			cmp("ready", !e_ld, instr_ready_out);
			cmp("rd_en", cl, mem_rd_en_out);
			f = instr_in[7:0];
			a = ext_set_en_in && f < 8'h60 ? index_base_in + f : {f < 8'h60 ? 4'h0 : 4'hF, f};
			if (instr_in[8]) a = {bank_select_reg_in, f};
			if (cl) cmp("rd_addr", a, mem_rd_addr_out);
			e_ld = br;
			e_tg = program_counter_in + 21'h2 + {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
			e_wr = cl;
			e_wa = a;
			e_wd = sh[a] & ~(8'h01 << instr_in[11:9]);
			if (cl) sh[a] = e_wd;
		end
		$display("random word mix done");
		stop_test;
	end
endmodule
bind carry_branch_and_bit_clear_exec carry_branch_and_bit_clear_exec_checker u_chk (.clk_in,
	.rst_n_in, .instr_valid_in, .instr_in, .program_counter_in, .carry_flag_in, .mem_rd_en_out,
	.mem_wr_en_out, .pc_load_out, .pc_target_out, .nop_cycle_out, .instr_ready_out);
